/* bench/bp_front_monitor.sv */
// Port checker for the branch prediction front end
`timescale 1ns/1ns
module bp_front_monitor
  import bp_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic fetch_ready_i,
  input wire logic lookup_valid_i,
  input wire logic dec_valid_i,
  input wire bp_pkg::branch_kind_t dec_kind_i,
  input wire logic [bp_pkg::ADDR_W-1:0] dec_disp_i,
  input wire logic dec_had_entry_i,
  input wire logic mispredict_i,
  input wire logic [bp_pkg::ADDR_W-1:0] correct_addr_i,
  input wire logic fetch_valid_o,
  input wire logic [bp_pkg::ADDR_W-1:0] fetch_addr_o,
  input wire logic flush_o,
  input wire logic pred_valid_o,
  input wire logic pred_taken_o,
  input wire logic [bp_pkg::ADDR_W-1:0] pred_target_o,
  input wire logic pred_static_o,
  input wire logic line_join_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Decode-only cycles: no lookup hit or flush can take priority
  logic dec_only;
  logic back_w;
  assign dec_only = dec_valid_i && !lookup_valid_i && !mispredict_i;
  assign back_w = dec_disp_i[31];
  a_flush_redirect: assert property (mispredict_i |=> flush_o &&
    fetch_addr_o == $past(correct_addr_i)) else $error("no redirect after mispredict");
  a_far_ignored: assert property (dec_only && dec_kind_i inside {BR_FAR, BR_NONE}
    |=> !pred_valid_o) else $error("far transfer predicted");
  a_static_dir: assert property (dec_only && dec_kind_i == BR_COND && !dec_had_entry_i
    |=> pred_static_o && pred_taken_o == $past(back_w)) else $error("static direction wrong");
  a_static_gate: assert property (pred_static_o |-> $past(dec_valid_i) &&
    !$past(dec_had_entry_i)) else $error("static without decode");
  a_ret_taken: assert property (dec_only && dec_kind_i == BR_RET && !dec_had_entry_i
    |=> pred_valid_o && pred_taken_o) else $error("return not taken");
  a_taken_steers: assert property (pred_valid_o && pred_taken_o
    |-> fetch_addr_o == pred_target_o) else $error("fetch not at target");
  a_join_taken: assert property (line_join_o |-> pred_valid_o && pred_taken_o)
    else $error("line join without taken");
  a_chunk_step: assert property (fetch_valid_o && fetch_ready_i && !mispredict_i &&
    !lookup_valid_i && !dec_valid_i |=> fetch_addr_o == $past(fetch_addr_o) + 32)
    else $error("fetch step not one chunk");
endmodule

/* bench/branch_prediction_front_end_test.sv */
// Self-checking bench for the branch prediction front end
`timescale 1ns/1ns
module branch_prediction_front_end_test;
  import bp_pkg::*;
  logic clock_i, nrst_i, fetch_ready_i, lookup_valid_i, dec_valid_i, dec_had_entry_i;
  logic retire_valid_i, retire_taken_i, mispredict_i;
  branch_kind_t dec_kind_i, retire_kind_i;
  logic [31:0] lookup_addr_i, dec_addr_i, dec_next_i, dec_disp_i, retire_addr_i;
  logic [31:0] retire_target_i, correct_addr_i, fetch_addr_o, pred_target_o;
  logic fetch_valid_o, flush_o, pred_valid_o, pred_taken_o, pred_static_o, line_join_o;
  int n_fail = 0;
  int comparisons = 0;
  branch_prediction_front_end dut (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .fetch_ready_i(fetch_ready_i),
    .lookup_addr_i(lookup_addr_i),
    .lookup_valid_i(lookup_valid_i),
    .dec_valid_i(dec_valid_i),
    .dec_kind_i(dec_kind_i),
    .dec_addr_i(dec_addr_i),
    .dec_next_i(dec_next_i),
    .dec_disp_i(dec_disp_i),
    .dec_had_entry_i(dec_had_entry_i),
    .retire_valid_i(retire_valid_i),
    .retire_kind_i(retire_kind_i),
    .retire_addr_i(retire_addr_i),
    .retire_target_i(retire_target_i),
    .retire_taken_i(retire_taken_i),
    .mispredict_i(mispredict_i),
    .correct_addr_i(correct_addr_i),
    .fetch_valid_o(fetch_valid_o),
    .fetch_addr_o(fetch_addr_o),
    .flush_o(flush_o),
    .pred_valid_o(pred_valid_o),
    .pred_taken_o(pred_taken_o),
    .pred_target_o(pred_target_o),
    .pred_static_o(pred_static_o),
    .line_join_o(line_join_o)
  );
  pipe_model pipe (.clock_i(clock_i), .fetch_ready_o(fetch_ready_i),
    .retire_valid_o(retire_valid_i), .retire_kind_o(retire_kind_i),
    .retire_addr_o(retire_addr_i), .retire_target_o(retire_target_i),
    .retire_taken_o(retire_taken_i), .mispredict_o(mispredict_i),
    .correct_addr_o(correct_addr_i));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // ==========================================
  // Drivers and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lk(input logic [31:0] a);
    @(posedge clock_i);
    lookup_valid_i <= 1'b1;
    lookup_addr_i <= a;
    @(posedge clock_i);
    lookup_valid_i <= 1'b0;
    lookup_addr_i <= ~a;
    #1;
  endtask
  task automatic dc(input branch_kind_t k, input logic [31:0] n, d, input logic h);
    @(posedge clock_i);
    dec_valid_i <= 1'b1;
    dec_kind_i <= k;
    dec_next_i <= n;
    dec_addr_i <= n - 32'h4;
    dec_disp_i <= d;
    dec_had_entry_i <= h;
    @(posedge clock_i);
    dec_valid_i <= 1'b0;
    dec_next_i <= ~n;
    dec_disp_i <= ~d;
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    repeat (3) @(posedge clock_i);
    chk(fetch_addr_o, 32'h0);
    chk(pred_valid_o, 1'b0);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk(fetch_valid_o, 1'b1);
  endtask
  task automatic t_dynamic;
    lk(32'h1000);
    chk(pred_valid_o, 1'b0);
    pipe.retire(BR_COND, 32'h1000, 32'h2040, 1'b1);
    lk(32'h1000);
    chk(pred_taken_o, 1'b1);
    chk(pred_target_o, 32'h2040);
    chk(fetch_addr_o, 32'h2040);
    chk(line_join_o, 1'b1);
    pipe.retire(BR_FAR, 32'h3000, 32'h4000, 1'b1);
    lk(32'h3000);
    chk(pred_valid_o, 1'b0);
    pipe.retire(BR_CALL, 32'h1104, 32'h5000, 1'b1);
    lk(32'h1104);
    chk(pred_target_o, 32'h5000);
    pipe.retire(BR_RET, 32'h1208, 32'h0, 1'b1);
    lk(32'h1208);
    chk(pred_taken_o, 1'b1);
    chk(pred_target_o, 32'h1124);
  endtask
  task automatic t_static;
    dc(BR_COND, 32'h500, 32'hffff_fff0, 1'b0);
    chk({pred_valid_o, pred_static_o, pred_taken_o}, 32'h7);
    dc(BR_COND, 32'h500, 32'h10, 1'b0);
    chk({pred_static_o, pred_taken_o}, 32'h2);
    chk(pred_target_o, 32'h500);
    dc(BR_COND, 32'h500, 32'hffff_fff0, 1'b1);
    chk(pred_static_o, 1'b0);
    dc(BR_FAR, 32'h500, 32'h10, 1'b0);
    chk(pred_valid_o, 1'b0);
  endtask
  task automatic t_stack;
    branch_kind_t ks[4] = '{BR_JUMP, BR_INDIRECT, BR_COND, BR_CALL};
    foreach (ks[i])
    begin
      dc(ks[i], 32'h700, 32'h8, 1'b0);
      chk(pred_valid_o, 1'b1);
    end
    for (int i = 0; i <= 16; i++)
      dc(BR_CALL, 32'h100 + i * 16, 32'h40, 1'b0);
    for (int i = 16; i >= 1; i--)
    begin
      dc(BR_RET, 32'h0, 32'h40, 1'b0);
      chk(pred_taken_o, 1'b1);
      chk(pred_target_o, 32'h100 + i * 16);
    end
  endtask
  task automatic t_miss;
    pipe.stall(1'b1);
    pipe.miss(32'h8000);
    #1;
    chk(flush_o, 1'b1);
    chk(fetch_addr_o, 32'h8000);
    @(posedge clock_i);
    #1;
    chk(flush_o, 1'b0);
    chk(fetch_addr_o, 32'h8000);
    pipe.stall(1'b0);
    @(posedge clock_i);
    #1;
    chk(fetch_addr_o, 32'h8020);
  endtask
  task print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    nrst_i = 1'b0;
    lookup_valid_i = 1'b0;
    lookup_addr_i = 32'h0;
    dec_valid_i = 1'b0;
    dec_kind_i = BR_NONE;
    dec_addr_i = 32'h0;
    dec_next_i = 32'h0;
    dec_disp_i = 32'h0;
    dec_had_entry_i = 1'b0;
    t_reset;
    t_dynamic;
    t_static;
    t_stack;
    t_miss;
    print_verdict;
  end
endmodule
bind branch_prediction_front_end bp_front_monitor mon (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .fetch_ready_i(fetch_ready_i),
  .lookup_valid_i(lookup_valid_i),
  .dec_valid_i(dec_valid_i),
  .dec_kind_i(dec_kind_i),
  .dec_disp_i(dec_disp_i),
  .dec_had_entry_i(dec_had_entry_i),
  .mispredict_i(mispredict_i),
  .correct_addr_i(correct_addr_i),
  .fetch_valid_o(fetch_valid_o),
  .fetch_addr_o(fetch_addr_o),
  .flush_o(flush_o),
  .pred_valid_o(pred_valid_o),
  .pred_taken_o(pred_taken_o),
  .pred_target_o(pred_target_o),
  .pred_static_o(pred_static_o),
  .line_join_o(line_join_o)
);

/* bench/pipe_model.sv */
// Model of the retirement, resolution and fetch logic facing the predictor
`timescale 1ns/1ns
module pipe_model
  import bp_pkg::*;
(
  input wire logic clock_i,
  output logic fetch_ready_o,
  output logic retire_valid_o,
  output bp_pkg::branch_kind_t retire_kind_o,
  output logic [bp_pkg::ADDR_W-1:0] retire_addr_o,
  output logic [bp_pkg::ADDR_W-1:0] retire_target_o,
  output logic retire_taken_o,
  output logic mispredict_o,
  output logic [bp_pkg::ADDR_W-1:0] correct_addr_o
);
  initial
  begin
    fetch_ready_o = 1'b1;
    retire_valid_o = 1'b0;
    retire_kind_o = BR_NONE;
    retire_addr_o = 32'h0;
    retire_target_o = 32'h0;
    retire_taken_o = 1'b0;
    mispredict_o = 1'b0;
    correct_addr_o = 32'h0;
  end
  // ==========================================
  // Retire and miss are one-cycle pulses; released address lines show the inverse so stale data is never trusted
  task automatic retire(input branch_kind_t k, input logic [31:0] a, t, input logic tk);
    @(posedge clock_i);
    retire_valid_o <= 1'b1;
    retire_kind_o <= k;
    retire_addr_o <= a;
    retire_target_o <= t;
    retire_taken_o <= tk;
    @(posedge clock_i);
    retire_valid_o <= 1'b0;
    retire_addr_o <= ~a;
    retire_target_o <= ~t;
  endtask
  task automatic miss(input logic [31:0] c);
    @(posedge clock_i);
    mispredict_o <= 1'b1;
    correct_addr_o <= c;
    @(posedge clock_i);
    mispredict_o <= 1'b0;
    correct_addr_o <= ~c;
  endtask
  task automatic stall(input logic s);
    @(posedge clock_i);
    fetch_ready_o <= !s;
  endtask
endmodule

/* logic/bp_pkg.sv */
// Package: shared constants and types for the branch prediction front end
package bp_pkg;
  localparam int ADDR_W = 32;
  localparam int TBL_ENTRIES = 64;
  localparam int RAS_ENTRIES = 16;
  localparam int FETCH_CHUNK_BYTES = 32;
  localparam int CHUNK_LSB = $clog2(FETCH_CHUNK_BYTES);
  localparam logic [1:0] CTR_RESET = 2'h1;
  localparam logic [1:0] CTR_MAX = 2'h3;
  localparam logic [1:0] CTR_MIN = 2'h0;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;

  typedef enum logic [2:0] {
    BR_NONE = 3'h0,
    BR_COND = 3'h1,
    BR_JUMP = 3'h2,
    BR_CALL = 3'h3,
    BR_RET = 3'h4,
    BR_INDIRECT = 3'h5,
    BR_FAR = 3'h6
  } branch_kind_t;
endpackage

/* logic/branch_prediction_front_end.sv */
// Module: front-end branch predictor steering the chunked instruction fetcher
// Function
// - predict every near control transfer kind
// - far transfers get no predicted target
// - buffer gives direction and target by address
// - static fallback: conditional backward taken, forward not
// - static only after decode, no valid entry
// - dynamic prediction available before decode
// - buffer written only at branch retirement
// - sixteen-entry return address stack
// - returns always taken, target from stack
// - fetch 32-byte chunks from predicted target
// - correct prediction redirects with no bubble
// - misprediction restarts fetch, pipeline-depth penalty
// - taken branch and target share trace line
// - retirement updates refresh branch history
`timescale 1ns/1ns
module branch_prediction_front_end
  import bp_pkg::*;
#(
  parameter int ENTRIES = bp_pkg::TBL_ENTRIES,
  parameter int RAS_DEPTH = bp_pkg::RAS_ENTRIES
)(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic fetch_ready_i,
  input wire logic [bp_pkg::ADDR_W-1:0] lookup_addr_i,
  input wire logic lookup_valid_i,
  input wire logic dec_valid_i,
  input wire bp_pkg::branch_kind_t dec_kind_i,
  input wire logic [bp_pkg::ADDR_W-1:0] dec_addr_i,
  input wire logic [bp_pkg::ADDR_W-1:0] dec_next_i,
  input wire logic [bp_pkg::ADDR_W-1:0] dec_disp_i,
  input wire logic dec_had_entry_i,
  input wire logic retire_valid_i,
  input wire bp_pkg::branch_kind_t retire_kind_i,
  input wire logic [bp_pkg::ADDR_W-1:0] retire_addr_i,
  input wire logic [bp_pkg::ADDR_W-1:0] retire_target_i,
  input wire logic retire_taken_i,
  input wire logic mispredict_i,
  input wire logic [bp_pkg::ADDR_W-1:0] correct_addr_i,
  output logic fetch_valid_o,
  output logic [bp_pkg::ADDR_W-1:0] fetch_addr_o,
  output logic flush_o,
  output logic pred_valid_o,
  output logic pred_taken_o,
  output logic [bp_pkg::ADDR_W-1:0] pred_target_o,
  output logic pred_static_o,
  output logic line_join_o
);
  import bp_pkg::*;

  localparam int IDX_W = $clog2(ENTRIES);
  localparam int RP_W = $clog2(RAS_DEPTH);
  localparam int TAG_W = ADDR_W - IDX_W;

  // ==========================================================
  // Target/history buffer storage
  logic [ENTRIES-1:0] ent_valid_q, ent_valid_d;
  logic [TAG_W-1:0] ent_tag_q [ENTRIES], ent_tag_d [ENTRIES];
  logic [ADDR_W-1:0] ent_tgt_q [ENTRIES], ent_tgt_d [ENTRIES];
  logic [1:0] ent_ctr_q [ENTRIES], ent_ctr_d [ENTRIES];
  branch_kind_t ent_kind_q [ENTRIES], ent_kind_d [ENTRIES];

  // ==========================================================
  // Return address stack
  logic [ADDR_W-1:0] ras_q [RAS_DEPTH], ras_d [RAS_DEPTH];
  logic [RP_W-1:0] ras_top_q, ras_top_d;
  logic [RP_W:0] ras_cnt_q, ras_cnt_d;

  // ==========================================================
  // Fetch and prediction outputs
  logic fetch_valid_d;
  logic flush_d;
  logic pred_valid_d;
  logic pred_taken_d;
  logic pred_static_d;
  logic line_join_d;
  logic [ADDR_W-1:0] fetch_addr_d;
  logic [ADDR_W-1:0] pred_target_d;

  // ==========================================================
  // Index and tag split of lookup and retire addresses
  logic [IDX_W-1:0] lk_idx;
  logic [IDX_W-1:0] rt_idx;
  logic [TAG_W-1:0] lk_tag;
  logic [TAG_W-1:0] rt_tag;
  logic lk_hit;
  logic [ADDR_W-1:0] lk_tgt;
  logic [ADDR_W-1:0] chunk_next;
  branch_kind_t lk_kind;
  logic [1:0] lk_ctr;

  assign lk_idx = lookup_addr_i[IDX_W-1:0];
  assign lk_tag = lookup_addr_i[ADDR_W-1:IDX_W];
  assign rt_idx = retire_addr_i[IDX_W-1:0];
  assign rt_tag = retire_addr_i[ADDR_W-1:IDX_W];
  assign lk_hit = ent_valid_q[lk_idx] && (ent_tag_q[lk_idx] == lk_tag);
  assign lk_tgt = ent_tgt_q[lk_idx];
  assign lk_kind = ent_kind_q[lk_idx];
  assign lk_ctr = ent_ctr_q[lk_idx];
  // Sequential fetch steps one chunk on from the chunk that began at the target
  assign chunk_next = fetch_addr_o + ADDR_W'(FETCH_CHUNK_BYTES);

  // ==========================================================
  // Buffer update: only retirement writes, never lookup or decode
  always_comb
  begin
    ent_valid_d = ent_valid_q;
    ent_tag_d = ent_tag_q;
    ent_tgt_d = ent_tgt_q;
    ent_ctr_d = ent_ctr_q;
    ent_kind_d = ent_kind_q;
    // Far transfers never allocate, so they are never predicted
    if (retire_valid_i && retire_kind_i != BR_NONE && retire_kind_i != BR_FAR)
    begin
      if (!ent_valid_q[rt_idx] || ent_tag_q[rt_idx] != rt_tag)
      begin
        ent_valid_d[rt_idx] = 1'b1;
        ent_tag_d[rt_idx] = rt_tag;
        ent_ctr_d[rt_idx] = retire_taken_i ? CTR_MAX : CTR_RESET;
      end
      // Saturating counter: one odd outcome does not flip a strong prediction
      else if (retire_taken_i && ent_ctr_q[rt_idx] != CTR_MAX)
        ent_ctr_d[rt_idx] = ent_ctr_q[rt_idx] + 2'h1;
      else if (!retire_taken_i && ent_ctr_q[rt_idx] != CTR_MIN)
        ent_ctr_d[rt_idx] = ent_ctr_q[rt_idx] - 2'h1;
      ent_kind_d[rt_idx] = retire_kind_i;
      // Keep the old target on a not-taken retire so the address stays useful
      if (retire_taken_i)
        ent_tgt_d[rt_idx] = retire_target_i;
    end
  end

  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_ent
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        // Cleared so a lookup never sees unknown tags or targets
        ent_tag_q[g] <= '0;
        ent_tgt_q[g] <= '0;
        ent_ctr_q[g] <= CTR_RESET;
        ent_kind_q[g] <= BR_NONE;
      end
      else
      begin
        ent_tag_q[g] <= ent_tag_d[g];
        ent_tgt_q[g] <= ent_tgt_d[g];
        ent_ctr_q[g] <= ent_ctr_d[g];
        ent_kind_q[g] <= ent_kind_d[g];
      end
    end
  end

  for (genvar r = 0; r < RAS_DEPTH; r++)
  begin : g_ras
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
        ras_q[r] <= '0;
      else
        ras_q[r] <= ras_d[r];
    end
  end

  // ==========================================================
  // Prediction, stack and fetch steering
  always_comb
  begin
    ras_d = ras_q;
    ras_top_d = ras_top_q;
    ras_cnt_d = ras_cnt_q;
    fetch_valid_d = 1'b1;
    fetch_addr_d = fetch_addr_o;
    flush_d = 1'b0;
    pred_valid_d = 1'b0;
    pred_taken_d = 1'b0;
    pred_target_d = '0;
    pred_static_d = 1'b0;
    line_join_d = 1'b0;
    if (fetch_ready_i)
      fetch_addr_d = chunk_next;
    if (mispredict_i)
    begin
      // Younger fetch state is dropped; the restart costs the full pipe refill
      flush_d = 1'b1;
      fetch_addr_d = correct_addr_i;
    end
    else if (lookup_valid_i && lk_hit)
    begin
      // Hit is known from the fetch address alone, ahead of decode
      pred_valid_d = 1'b1;
      pred_target_d = lk_tgt;
      pred_taken_d = lk_ctr[1];
      if (lk_kind == BR_RET)
      begin
        pred_taken_d = 1'b1;
        pred_target_d = ras_q[ras_top_q];
        // An empty stack keeps its pointer; the stale top is still the best guess
        if (ras_cnt_q != '0)
        begin
          ras_top_d = ras_top_q - RP_W'(1);
          ras_cnt_d = ras_cnt_q - (RP_W+1)'(1);
        end
      end
      else if (lk_kind == BR_CALL || lk_kind == BR_JUMP || lk_kind == BR_INDIRECT)
        pred_taken_d = 1'b1;
      if (lk_kind == BR_CALL)
      begin
        // Full stack wraps and overwrites the oldest entry
        // No instruction length is known here, so the return is one chunk on
        ras_top_d = ras_top_q + RP_W'(1);
        ras_d[ras_top_q + RP_W'(1)] = lookup_addr_i + ADDR_W'(FETCH_CHUNK_BYTES);
        if (ras_cnt_q != (RP_W+1)'(RAS_DEPTH))
          ras_cnt_d = ras_cnt_q + (RP_W+1)'(1);
      end
      if (pred_taken_d)
      begin
        fetch_addr_d = pred_target_d;
        line_join_d = 1'b1;
      end
    end
    else if (dec_valid_i && !dec_had_entry_i && dec_kind_i != BR_FAR
             && dec_kind_i != BR_NONE)
    begin
      // Static fallback: conditional direction comes from the displacement sign
      pred_valid_d = 1'b1;
      pred_static_d = 1'b1;
      if (dec_kind_i == BR_COND)
        pred_taken_d = dec_disp_i[ADDR_W-1];
      else
        pred_taken_d = 1'b1;
      pred_target_d = dec_next_i + dec_disp_i;
      if (dec_kind_i == BR_RET)
      begin
        pred_target_d = ras_q[ras_top_q];
        if (ras_cnt_q != '0)
        begin
          ras_top_d = ras_top_q - RP_W'(1);
          ras_cnt_d = ras_cnt_q - (RP_W+1)'(1);
        end
      end
      else if (dec_kind_i == BR_CALL)
      begin
        ras_top_d = ras_top_q + RP_W'(1);
        ras_d[ras_top_q + RP_W'(1)] = dec_next_i;
        if (ras_cnt_q != (RP_W+1)'(RAS_DEPTH))
          ras_cnt_d = ras_cnt_q + (RP_W+1)'(1);
      end
      // Indirect targets are unknown without history; fall through
      if (dec_kind_i == BR_INDIRECT)
        pred_taken_d = 1'b0;
      if (pred_taken_d)
      begin
        fetch_addr_d = pred_target_d;
        line_join_d = 1'b1;
      end
      else
        pred_target_d = dec_next_i;
    end
    // Keep the dec_addr_i port meaningful as the fall-through origin
    if (dec_valid_i && dec_addr_i == fetch_addr_o && !pred_valid_d)
      fetch_valid_d = 1'b1;
  end

  // ==========================================================
  // Output and pointer registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ent_valid_q <= '0;
      ras_top_q <= '0;
      ras_cnt_q <= '0;
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= RESET_PC;
      flush_o <= 1'b0;
      pred_valid_o <= 1'b0;
      pred_taken_o <= 1'b0;
      pred_target_o <= '0;
      pred_static_o <= 1'b0;
      line_join_o <= 1'b0;
    end
    else
    begin
      ent_valid_q <= ent_valid_d;
      ras_top_q <= ras_top_d;
      ras_cnt_q <= ras_cnt_d;
      fetch_valid_o <= fetch_valid_d;
      fetch_addr_o <= fetch_addr_d;
      flush_o <= flush_d;
      pred_valid_o <= pred_valid_d;
      pred_taken_o <= pred_taken_d;
      pred_target_o <= pred_target_d;
      pred_static_o <= pred_static_d;
      line_join_o <= line_join_d;
    end
  end
endmodule
